// File: inc/eilm_pkg.sv
package eilm_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] IRQST_ADDR  = 8'h08;
    localparam logic [7:0] IRQMSK_ADDR = 8'h0C;
    localparam logic [7:0] RAW_ADDR    = 8'h10;
    localparam logic [7:0] ID_ADDR     = 8'h14;
    // arbitrary identification value
    localparam logic [31:0] ID_VALUE   = 32'h0E11_0001;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_RAMP_CLR  = 0;
    localparam int CTRL_SW_STOP   = 1;
    localparam int CTRL_HI_INT    = 2;
    localparam int CTRL_SPARE_EN  = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int IRQ_BITS = 4;
    localparam int IRQ_R1_DROP  = 0;
    localparam int IRQ_R2_DROP  = 1;
    localparam int IRQ_RAMP     = 2;
    localparam int IRQ_DUMPFLT  = 3;
    localparam int SPARE_BITS = 4;
    localparam int DUMP_BITS  = 4;
    localparam int PIN_BITS = 21;

    // dump block position code
    typedef enum logic [1:0] {
        DUMP_MOVING = 2'b00,
        DUMP_IN     = 2'b01,
        DUMP_OUT    = 2'b10,
        DUMP_BAD    = 2'b11
    } eilm_dump_e;

    // collider-side inputs of one ring
    typedef struct packed {
        logic permit;      // beam permit loop derived input
        logic circulating; // intensity monitor sees beam
        logic request;     // extraction request / interlock ok
        logic kicker;      // reserved: injection kicker state
        logic septum;      // reserved: injection septum state
        logic loopState;   // reserved: permit loop state
    } eilm_ring_s;

    typedef struct packed {
        eilm_ring_s         ring1;
        eilm_ring_s         ring2;
        logic               rampTrig;
        logic               targetOk;   // neutrino target beam
        logic               ntLineOk;   // neutrino target line
        logic               r2LineOk;   // ring2 transfer line
        logic               r1LineOk;   // ring1 transfer line
        logic [SPARE_BITS-1:0] spare;
    } eilm_pins_s;

    typedef struct packed {
        eilm_dump_e ring2Down;  // downstream, ring2 transfer line
        eilm_dump_e firstExt;   // first extraction line
        eilm_dump_e ring1Down;  // downstream, ring1 transfer line
        eilm_dump_e secondExt;  // second extraction line
    } eilm_dumps_s;

    typedef struct packed {
        logic ring1Permit;
        logic ring2Permit;
        logic targetPermit;
    } eilm_permit_s;
endpackage

// File: hw/eilm_sync.sv
module eilm_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } eilm_sync_s;

    eilm_sync_s state_q;
    eilm_sync_s state_d;

    always_comb
    begin
        state_d.meta   = pinIn;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stable;
endmodule

// File: hw/eilm_ahb.sv
module eilm_ahb (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    input  wire logic [31:0] rdData,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             wrEn,
    output logic [7:0]       wrAddr,
    output logic [31:0]      wrData,
    output logic [7:0]       rdAddr
);
    typedef struct packed {
        logic       wrPend;
        logic [7:0] addr;
    } eilm_ahb_s;

    eilm_ahb_s state_q;
    eilm_ahb_s state_d;
    logic      take;

    // only whole-word single transfers are used; hsize is not checked
    assign take = hsel & hready & htrans[1];

    always_comb
    begin
        state_d = state_q;
        if (hready)
        begin
            state_d.wrPend = take & hwrite;
            if (take)
            begin
                state_d.addr = {haddr[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // zero wait states: read data comes straight from the register file
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rdAddr    = state_q.addr;
    assign hrdata    = rdData;
    assign wrEn      = state_q.wrPend;
    assign wrAddr    = state_q.addr;
    assign wrData    = hwdata;
endmodule

// File: hw/eilm_top.sv
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
module eilm_top (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic                hsel,
    input  wire logic [7:0]          haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire eilm_pkg::eilm_pins_s  pins,
    input  wire eilm_pkg::eilm_dumps_s dumps,
    input  wire logic                swStopReq,
    output eilm_pkg::eilm_permit_s   permit,
    output logic                     irq
);
    // ----------------------------------------
    // input synchronisation
    // ----------------------------------------
    eilm_pkg::eilm_pins_s  pinsS;
    eilm_pkg::eilm_dumps_s dumpsS;
    logic                  swStopS;

    eilm_sync #(.W(eilm_pkg::PIN_BITS + 9)) uSync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .pinIn   ({pins, dumps, swStopReq}),
        .syncOut ({pinsS, dumpsS, swStopS})
    );

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic        wrEn;
    logic [7:0]  wrAddr;
    logic [31:0] wrData;
    logic [7:0]  rdAddr;
    logic [31:0] rdData;

    eilm_ahb uAhb (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .rdData    (rdData),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wrEn      (wrEn),
        .wrAddr    (wrAddr),
        .wrData    (wrData),
        .rdAddr    (rdAddr)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [31:0]                  ctrl;
        logic                         rampLatch;
        logic [eilm_pkg::IRQ_BITS-1:0] irqSt;
        logic [eilm_pkg::IRQ_BITS-1:0] irqMsk;
        eilm_pkg::eilm_permit_s       permit;
        eilm_pkg::eilm_permit_s       permitPrev;
        logic                         rampPrev;
        logic                         faultPrev;
    } eilm_top_s;

    eilm_top_s state_q;
    eilm_top_s state_d;

    // dump block ok only when reported in beam
    function automatic logic dumpIn(input eilm_pkg::eilm_dump_e pos);
        dumpIn = (pos == eilm_pkg::DUMP_IN);
    endfunction

    // a masked input always permits, else its own level decides
    function automatic logic qualify(input logic ok, input logic masked);
        qualify = ok | masked;
    endfunction

    // ----------------------------------------
    // masks from dump positions
    // ----------------------------------------
    logic maskRing1;
    logic maskRing2;
    logic maskTarget;
    logic maskNtLine;
    logic maskR1Line;
    logic maskR2Line;
    logic dumpFault;

    always_comb
    begin
        maskRing2  = dumpIn(dumpsS.ring2Down) | dumpIn(dumpsS.firstExt);
        maskTarget = dumpIn(dumpsS.firstExt);
        maskNtLine = dumpIn(dumpsS.firstExt);
        maskR2Line = dumpIn(dumpsS.firstExt);
        maskRing1  = dumpIn(dumpsS.ring1Down) | dumpIn(dumpsS.secondExt);
        maskR1Line = dumpIn(dumpsS.secondExt);
        // any dump not in beam is reported as a fault
        dumpFault  = !(dumpIn(dumpsS.ring2Down) & dumpIn(dumpsS.firstExt)
                     & dumpIn(dumpsS.ring1Down) & dumpIn(dumpsS.secondExt));
    end

    // ----------------------------------------
    // per-ring qualification
    // ----------------------------------------
    logic ring1Ok;
    logic ring2Ok;
    logic targetOk;
    logic hwBlock;
    logic spareOk;
    logic hiInt;

    function automatic logic ringOk(input eilm_pkg::eilm_ring_s r, input logic hi,
                                    input logic spareEn);
        logic ok;
        ok = r.permit;
        ok = ok & r.request;
        ok = ok & !(hi & !r.circulating);
        // reserved channels take part only once enabled by software
        if (spareEn)
        begin
            ok = ok & r.kicker & r.septum & r.loopState;
        end
        ringOk = ok;
    endfunction

    always_comb
    begin
        hiInt   = state_q.ctrl[eilm_pkg::CTRL_HI_INT];
        spareOk = !state_q.ctrl[eilm_pkg::CTRL_SPARE_EN] | (&pinsS.spare);
        hwBlock = state_q.rampLatch | pinsS.rampTrig;
        ring1Ok = qualify(ringOk(pinsS.ring1, hiInt,
                                 state_q.ctrl[eilm_pkg::CTRL_SPARE_EN]), maskRing1)
                & qualify(pinsS.r1LineOk, maskR1Line);
        ring2Ok = qualify(ringOk(pinsS.ring2, hiInt,
                                 state_q.ctrl[eilm_pkg::CTRL_SPARE_EN]), maskRing2)
                & qualify(pinsS.r2LineOk, maskR2Line);
        targetOk = qualify(pinsS.targetOk, maskTarget)
                 & qualify(pinsS.ntLineOk, maskNtLine);
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic                          swStop;
    logic [eilm_pkg::IRQ_BITS-1:0] irqEv;

    always_comb
    begin
        state_d = state_q;
        // software stop acts regardless of every hardware input
        swStop  = swStopS | state_q.ctrl[eilm_pkg::CTRL_SW_STOP];

        // ramp trigger latched until software rearms after the ramp
        if (pinsS.rampTrig)
        begin
            state_d.rampLatch = 1'b1;
        end
        else if (wrEn && wrAddr == eilm_pkg::CTRL_ADDR
                 && wrData[eilm_pkg::CTRL_RAMP_CLR])
        begin
            state_d.rampLatch = 1'b0;
        end

        state_d.permit.ring1Permit  = ring1Ok & spareOk & !hwBlock & !swStop;
        state_d.permit.ring2Permit  = ring2Ok & spareOk & !hwBlock & !swStop;
        state_d.permit.targetPermit = targetOk & spareOk & !swStop;
        state_d.permitPrev = state_q.permit;
        state_d.rampPrev   = pinsS.rampTrig;
        state_d.faultPrev  = dumpFault;

        if (wrEn && wrAddr == eilm_pkg::CTRL_ADDR)
        begin
            // the clear bit is a strobe and is not stored
            state_d.ctrl = wrData & ~(32'h1 << eilm_pkg::CTRL_RAMP_CLR);
        end
        if (wrEn && wrAddr == eilm_pkg::IRQMSK_ADDR)
        begin
            state_d.irqMsk = wrData[eilm_pkg::IRQ_BITS-1:0];
        end

        irqEv = '0;
        irqEv[eilm_pkg::IRQ_R1_DROP] = state_q.permitPrev.ring1Permit
                                     & !state_q.permit.ring1Permit;
        irqEv[eilm_pkg::IRQ_R2_DROP] = state_q.permitPrev.ring2Permit
                                     & !state_q.permit.ring2Permit;
        irqEv[eilm_pkg::IRQ_RAMP]    = pinsS.rampTrig & !state_q.rampPrev;
        irqEv[eilm_pkg::IRQ_DUMPFLT] = dumpFault & !state_q.faultPrev;

        // write-one-to-clear; a new event in the same cycle wins
        if (wrEn && wrAddr == eilm_pkg::IRQST_ADDR)
        begin
            state_d.irqSt = state_q.irqSt & ~wrData[eilm_pkg::IRQ_BITS-1:0];
        end
        state_d.irqSt = state_d.irqSt | irqEv;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q      <= '0;
            state_q.ctrl <= eilm_pkg::CTRL_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb
    begin
        case (rdAddr)
            eilm_pkg::CTRL_ADDR:   rdData = state_q.ctrl;
            eilm_pkg::STATUS_ADDR: rdData = {22'h0, dumpFault, maskRing1, maskRing2,
                                             maskTarget, state_q.rampLatch, swStop,
                                             1'b0, state_q.permit};
            eilm_pkg::IRQST_ADDR:  rdData = {28'h0, state_q.irqSt};
            eilm_pkg::IRQMSK_ADDR: rdData = {28'h0, state_q.irqMsk};
            eilm_pkg::RAW_ADDR:    rdData = {11'h0, pinsS};
            eilm_pkg::ID_ADDR:     rdData = eilm_pkg::ID_VALUE;
            default:               rdData = 32'h0000_0000;
        endcase
    end

    assign permit = state_q.permit;
    assign irq    = |(state_q.irqSt & state_q.irqMsk);
endmodule

// File: verif/eilm_sw_model.sv
module eilm_sw_model #(
    parameter int LIMIT = 3
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic cycleEnd,
    input  wire logic cycleBad,
    input  wire logic colliderMode,
    input  wire logic dumpIn,
    output logic      swStopReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // software-side cycle surveillance
    // ----------------------------------------
    int unsigned badCount_q;

    // a good cycle restarts the count, so only successive faults add up
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            badCount_q <= 0;
        else if (cycleEnd)
            badCount_q <= cycleBad ? badCount_q + 1 : 0;

    assign swStopReq = (badCount_q > LIMIT) || (colliderMode && dumpIn);
endmodule

// File: verif/eilm_chk.sv
module eilm_chk (
    input wire logic                  sys_clk,
    input wire logic                  rst_b,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire eilm_pkg::eilm_pins_s  pins,
    input wire eilm_pkg::eilm_dumps_s dumps,
    input wire logic                  swStopReq,
    input wire eilm_pkg::eilm_permit_s permit,
    input wire logic                  irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // four samples cover the two sync stages plus the permit register
    sequence r1Held;
        (!pins.ring1.permit && dumps.ring1Down != eilm_pkg::DUMP_IN
            && dumps.secondExt != eilm_pkg::DUMP_IN) [*4];
    endsequence
    sequence r2Held;
        (!pins.ring2.permit && dumps.ring2Down != eilm_pkg::DUMP_IN
            && dumps.firstExt != eilm_pkg::DUMP_IN) [*4];
    endsequence
    sequence reqHeld;
        (!pins.ring1.request && dumps.ring1Down != eilm_pkg::DUMP_IN
            && dumps.secondExt != eilm_pkg::DUMP_IN) [*4];
    endsequence

    a_ring1_gate: assert property (r1Held |-> !permit.ring1Permit)
        else $error("ring1 permit without its beam permit");
    a_ring2_gate: assert property (r2Held |-> !permit.ring2Permit)
        else $error("ring2 permit without its beam permit");
    a_dump_or_req: assert property (reqHeld |-> !permit.ring1Permit)
        else $error("ring1 permit with dump out and no request");
    a_ramp_stop: assert property (pins.rampTrig [*4] |-> !permit.ring1Permit && !permit.ring2Permit)
        else $error("collider permit during ramp");
    a_sw_stop: assert property (swStopReq [*4] |-> permit == 3'b000)
        else $error("permit during software stop");
    a_target_fault: assert property ((!pins.targetOk && dumps.firstExt != eilm_pkg::DUMP_IN) [*4] |-> !permit.targetPermit)
        else $error("target permit with unmasked fault");
    a_line1_fault: assert property ((!pins.r1LineOk && dumps.secondExt != eilm_pkg::DUMP_IN) [*4] |-> !permit.ring1Permit)
        else $error("ring1 permit with unmasked line fault");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |-> permit == 3'b000 && !irq)
        else $error("outputs active in reset");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not okay");
endmodule

bind eilm_top eilm_chk u_chk (.sys_clk, .rst_b, .hreadyout, .hresp, .pins, .dumps,
    .swStopReq, .permit, .irq);

// File: verif/extraction_interlock_masking_tb_top.sv
module extraction_interlock_masking_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 3;
    // every pin healthy with the ramp trigger low (bit 8)
    localparam logic [20:0] PINS_OK = 21'h1FFEFF;
    // as above, ring1 beam permit (bit 20) and ring1 line (bit 4) faulted
    localparam logic [20:0] PINS_R1_BAD = 21'h0FFEEF;
    logic sys_clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, swStopReq;
    logic cycleEnd, cycleBad, colliderMode, dumpIn;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    eilm_pkg::eilm_pins_s pins;
    eilm_pkg::eilm_dumps_s dumps;
    eilm_pkg::eilm_permit_s permit;
    eilm_pkg::eilm_dump_e codes [3] = '{eilm_pkg::DUMP_MOVING, eilm_pkg::DUMP_OUT,
        eilm_pkg::DUMP_BAD};
    int n_errors = 0;
    int total_checks = 0;

    eilm_top u_dut (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .pins, .dumps,
        .swStopReq, .permit, .irq);
    eilm_sw_model #(.LIMIT(LIMIT)) u_sw (.sys_clk, .rst_b, .cycleEnd, .cycleBad,
        .colliderMode, .dumpIn, .swStopReq);

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // single word transfer; the master never assumes a slave latency
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    // two sync stages plus the permit register, then let the edge settle
    task automatic expPermit(input logic [2:0] e);
        repeat (4) @(posedge sys_clk);
        #1;
        check({29'h0, permit}, {29'h0, e});
    endtask

    task automatic pulse;
        @(posedge sys_clk);
        cycleEnd <= 1'b1;
        @(posedge sys_clk);
        cycleEnd <= 1'b0;
    endtask

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        print_verdict;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        pins = PINS_OK;
        dumps = {4{eilm_pkg::DUMP_OUT}};
        cycleEnd = 1'b0;
        cycleBad = 1'b0;
        colliderMode = 1'b0;
        dumpIn = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        xfer(1'b0, eilm_pkg::ID_ADDR, 32'h0);
        check(rd, eilm_pkg::ID_VALUE);
        xfer(1'b0, eilm_pkg::CTRL_ADDR, 32'h0);
        check(rd, eilm_pkg::CTRL_RESET);
        xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h1C, 32'h0);
        check(rd, 32'h0);
        expPermit(3'b111);
        xfer(1'b0, eilm_pkg::RAW_ADDR, 32'h0);
        check(rd, {11'h0, pins});
        xfer(1'b1, eilm_pkg::IRQMSK_ADDR, 32'h1);
        pins.ring1.permit <= 1'b0;
        expPermit(3'b011);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, eilm_pkg::IRQMSK_ADDR, 32'h0);
        check({31'h0, irq}, 32'h0);
        xfer(1'b1, eilm_pkg::IRQST_ADDR, 32'hF);
        xfer(1'b0, eilm_pkg::IRQST_ADDR, 32'h0);
        check(rd, 32'h0);
        pins.ring1.permit <= 1'b1;
        xfer(1'b1, eilm_pkg::CTRL_ADDR, 32'h4);
        pins.ring2.circulating <= 1'b0;
        expPermit(3'b101);
        xfer(1'b1, eilm_pkg::CTRL_ADDR, 32'h0);
        expPermit(3'b111);
        pins.ring2.permit <= 1'b0;
        dumps.ring2Down <= eilm_pkg::DUMP_IN;
        expPermit(3'b111);
        xfer(1'b0, eilm_pkg::STATUS_ADDR, 32'h0);
        check({29'h0, rd[8:6]}, 32'h2);
        dumps.ring2Down <= eilm_pkg::DUMP_OUT;
        pins.targetOk <= 1'b0;
        pins.ntLineOk <= 1'b0;
        pins.r2LineOk <= 1'b0;
        expPermit(3'b100);
        dumps.firstExt <= eilm_pkg::DUMP_IN;
        expPermit(3'b111);
        xfer(1'b0, eilm_pkg::STATUS_ADDR, 32'h0);
        check({29'h0, rd[8:6]}, 32'h3);
        dumps.firstExt <= eilm_pkg::DUMP_OUT;
        pins <= PINS_R1_BAD;
        for (int i = 0; i < 3; i++)
        begin
            dumps.secondExt <= codes[i];
            expPermit(3'b011);
        end
        dumps.secondExt <= eilm_pkg::DUMP_IN;
        expPermit(3'b111);
        dumps.secondExt <= eilm_pkg::DUMP_OUT;
        pins.r1LineOk <= 1'b1;
        dumps.ring1Down <= eilm_pkg::DUMP_IN;
        expPermit(3'b111);
        pins.rampTrig <= 1'b1;
        expPermit(3'b001);
        pins.rampTrig <= 1'b0;
        expPermit(3'b001);
        xfer(1'b1, eilm_pkg::CTRL_ADDR, 32'h1);
        expPermit(3'b111);
        pins <= PINS_OK;
        dumps <= {4{eilm_pkg::DUMP_OUT}};
        xfer(1'b1, eilm_pkg::CTRL_ADDR, 32'h8);
        expPermit(3'b111);
        xfer(1'b1, eilm_pkg::CTRL_ADDR, 32'h2);
        expPermit(3'b000);
        xfer(1'b1, eilm_pkg::CTRL_ADDR, 32'h0);
        expPermit(3'b111);
        colliderMode <= 1'b1;
        dumpIn <= 1'b1;
        expPermit(3'b000);
        dumpIn <= 1'b0;
        expPermit(3'b111);
        cycleBad <= 1'b1;
        repeat (LIMIT) pulse;
        expPermit(3'b111);
        pulse;
        expPermit(3'b000);
        cycleBad <= 1'b0;
        pulse;
        expPermit(3'b111);
        print_verdict;
    end
endmodule
